/* File: hw/sfps_defines.svh */
`ifndef SFPS_DEFINES_SVH
`define SFPS_DEFINES_SVH

// Clock and printed times
`define SFPS_CLK_NS 25
`define SFPS_WP_NS 200
`define SFPS_WPH_NS 200
`define SFPS_ACC_NS 200
`define SFPS_OEHP_NS 150
`define SFPS_BLC_US 150
`define SFPS_WC_MS 20

// Derived cycle counts, least times rounded up
`define SFPS_CEIL_CYC(ns) (((ns) + `SFPS_CLK_NS - 1) / `SFPS_CLK_NS)
`define SFPS_WP_CYC `SFPS_CEIL_CYC(`SFPS_WP_NS)
`define SFPS_WPH_CYC `SFPS_CEIL_CYC(`SFPS_WPH_NS)
`define SFPS_ACC_CYC `SFPS_CEIL_CYC(`SFPS_ACC_NS)
`define SFPS_OEHP_CYC `SFPS_CEIL_CYC(`SFPS_OEHP_NS)
`define SFPS_SYNC_CYC 3
// Longest times rounded down
`define SFPS_BLC_CYC ((`SFPS_BLC_US * 1000) / `SFPS_CLK_NS)
`define SFPS_WC_CYC ((`SFPS_WC_MS * 1000000) / `SFPS_CLK_NS)

// Bus cycle phases on the 8-bit phase counter
`define SFPS_WR_LO_FIRST 8'(1)
`define SFPS_WR_LO_END 8'(1 + `SFPS_WP_CYC)
`define SFPS_WR_LAST 8'(1 + `SFPS_WP_CYC + `SFPS_WPH_CYC)
`define SFPS_RD_SAMPLE 8'(`SFPS_ACC_CYC + `SFPS_SYNC_CYC)
`define SFPS_RD_LAST 8'(`SFPS_ACC_CYC + `SFPS_SYNC_CYC + `SFPS_OEHP_CYC)
`define SFPS_BUF_FETCH 8'h01

// Sequencing and field positions
`define SFPS_SEQ_LAST 3'h2
`define SFPS_LOCK_LAST 3'h3
`define SFPS_BYTE_LAST 8'hFF
`define SFPS_TOG_BIT 6
`define SFPS_SECT_HI 17
`define SFPS_SECT_LO 8
`define SFPS_TMR_W 20

`endif

/* File: hw/sfps_pkg.sv */
package sfps_pkg;

    typedef enum logic [2:0] {
        SFPS_ST_IDLE = 3'h0,
        SFPS_ST_CMD = 3'h1,
        SFPS_ST_LOAD = 3'h2,
        SFPS_ST_POLL = 3'h3,
        SFPS_ST_READ = 3'h4,
        SFPS_ST_DONE = 3'h5
    } sfps_state_t;

    typedef enum logic [2:0] {
        SFPS_CMD_READ = 3'h0,
        SFPS_CMD_PROG = 3'h1,
        SFPS_CMD_ID_READ = 3'h2,
        SFPS_CMD_LOCK_LOW = 3'h3,
        SFPS_CMD_LOCK_HIGH = 3'h4
    } sfps_cmd_t;

endpackage : sfps_pkg

/* File: hw/sfps_sector_buf.sv */
`timescale 1ns/1ps
`default_nettype none

module sfps_sector_buf (
    // Clock
    input wire logic core_clk_i,
    // Write side
    input wire logic wr_en_i,
    input wire logic [7:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    // Read side
    input wire logic [7:0] rd_addr_i,
    output logic [7:0] rd_data_o
);

    logic [7:0] mem_reg [256];
    logic [7:0] rd_data_reg;

    always_ff @(posedge core_clk_i) begin
        if (wr_en_i) begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        rd_data_reg <= mem_reg[rd_addr_i];
    end

    assign rd_data_o = rd_data_reg;

endmodule : sfps_sector_buf

`default_nettype wire

/* File: hw/sfps_host.sv */
// Operation
// - Protection command sequence always precedes the sector byte loads.
// - Every program operation loads all 256 bytes of the sector.
// - Sector number on upper address bits stays fixed for all loads.
// - Each byte load starts within the byte load window of the previous.
// - Polling reads use one constant address.
// - Command address on address bits 14..0, command byte on data.
`timescale 1ns/1ps
`default_nettype none
`include "sfps_defines.svh"

module sfps_host
    import sfps_pkg::*;
#(
    parameter int unsigned BLC_CYC = `SFPS_BLC_CYC,
    parameter int unsigned WC_CYC = `SFPS_WC_CYC,
    // Command sequence codes, values arbitrary
    parameter logic [14:0] SEQ_ADDR_A = 15'h0001,
    parameter logic [14:0] SEQ_ADDR_B = 15'h0002,
    parameter logic [7:0] SEQ_DATA_A = 8'h01,
    parameter logic [7:0] SEQ_DATA_B = 8'h02,
    parameter logic [7:0] OP_PROG = 8'h03,
    parameter logic [7:0] OP_ID_ENTRY = 8'h04,
    parameter logic [7:0] OP_ID_EXIT = 8'h05,
    parameter logic [7:0] OP_LOCK = 8'h06,
    parameter logic [7:0] LOCK_LOW_DATA = 8'h00,
    parameter logic [7:0] LOCK_HIGH_DATA = 8'h01
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Request
    input wire logic req_valid_i,
    input wire logic [2:0] req_cmd_i,
    input wire logic [17:0] req_addr_i,
    output logic req_ready_o,
    // Sector buffer fill
    input wire logic buf_wr_i,
    input wire logic [7:0] buf_waddr_i,
    input wire logic [7:0] buf_wdata_i,
    // Response
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o,
    output logic rsp_err_o,
    output logic busy_o,
    // Flash pins
    output logic ce_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic [17:0] byte_address_lines_o,
    output logic [7:0] data_byte_lines_o,
    output logic data_byte_lines_oe_o,
    input wire logic [7:0] data_byte_lines_i
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    sfps_state_t state_reg;
    sfps_cmd_t cmd_reg;
    logic [17:0] addr_reg;
    logic [7:0] cnt_reg;
    logic [2:0] step_reg;
    logic [7:0] idx_reg;
    logic exit_reg;
    logic have_prev_reg;
    logic prev_tog_reg;
    logic [`SFPS_TMR_W-1:0] wc_reg;
    logic [`SFPS_TMR_W-1:0] gap_reg;
    logic late_reg;
    logic err_reg;
    logic [7:0] dq_s1_reg;
    logic [7:0] dq_s2_reg;
    logic [7:0] buf_rdata;
    logic is_wr;
    logic is_rd;
    logic wr_end;
    logic rd_sample;
    logic rd_end;
    logic [22:0] seq_now;

    assign is_wr = (state_reg == SFPS_ST_CMD) || (state_reg == SFPS_ST_LOAD);
    assign is_rd = (state_reg == SFPS_ST_POLL) || (state_reg == SFPS_ST_READ);
    assign wr_end = is_wr && (cnt_reg == `SFPS_WR_LAST);
    assign rd_sample = is_rd && (cnt_reg == `SFPS_RD_SAMPLE);
    assign rd_end = is_rd && (cnt_reg == `SFPS_RD_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // Command sequence word: command address and command byte

    function automatic logic [22:0] seq_word(input sfps_cmd_t op, input logic [2:0] step,
                                             input logic leave);
        logic [7:0] opcode;
        opcode = OP_LOCK;
        if (leave) begin
            opcode = OP_ID_EXIT;
        end else if (op == SFPS_CMD_PROG) begin
            opcode = OP_PROG;
        end else if (op == SFPS_CMD_ID_READ) begin
            opcode = OP_ID_ENTRY;
        end
        unique case (step)
            3'h0: seq_word = {SEQ_ADDR_A, SEQ_DATA_A};
            3'h1: seq_word = {SEQ_ADDR_B, SEQ_DATA_B};
            3'h2: seq_word = {SEQ_ADDR_A, opcode};
            default: seq_word = {SEQ_ADDR_A,
                                 (op == SFPS_CMD_LOCK_HIGH) ? LOCK_HIGH_DATA : LOCK_LOW_DATA};
        endcase
    endfunction : seq_word

    function automatic logic [2:0] seq_last(input sfps_cmd_t op);
        if (op == SFPS_CMD_LOCK_LOW || op == SFPS_CMD_LOCK_HIGH) begin
            seq_last = `SFPS_LOCK_LAST;
        end else begin
            seq_last = `SFPS_SEQ_LAST;
        end
    endfunction : seq_last

    assign seq_now = seq_word(cmd_reg, step_reg, exit_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Sector buffer

    sfps_sector_buf u_buf (
        .core_clk_i(core_clk_i),
        .wr_en_i(buf_wr_i),
        .wr_addr_i(buf_waddr_i),
        .wr_data_i(buf_wdata_i),
        .rd_addr_i(idx_reg),
        .rd_data_o(buf_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Data input synchroniser

    always_ff @(posedge core_clk_i) begin
        dq_s1_reg <= data_byte_lines_i;
        dq_s2_reg <= dq_s1_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle phase counter

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || wr_end || rd_end || !(is_wr || is_rd)) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_reg <= SFPS_ST_IDLE;
            cmd_reg <= SFPS_CMD_READ;
            addr_reg <= 18'h00000;
            step_reg <= 3'h0;
            idx_reg <= 8'h00;
            exit_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                SFPS_ST_IDLE: begin
                    step_reg <= 3'h0;
                    idx_reg <= 8'h00;
                    exit_reg <= 1'b0;
                    err_reg <= 1'b0;
                    if (req_valid_i) begin
                        cmd_reg <= sfps_cmd_t'(req_cmd_i);
                        addr_reg <= req_addr_i;
                        if (req_cmd_i == SFPS_CMD_READ) begin
                            state_reg <= SFPS_ST_READ;
                        end else if (req_cmd_i <= SFPS_CMD_LOCK_HIGH) begin
                            state_reg <= SFPS_ST_CMD;
                        end else begin
                            err_reg <= 1'b1;
                            state_reg <= SFPS_ST_DONE;
                        end
                    end
                end
                SFPS_ST_CMD: begin
                    if (wr_end) begin
                        step_reg <= step_reg + 3'h1;
                        if (step_reg == seq_last(cmd_reg)) begin
                            step_reg <= 3'h0;
                            if (exit_reg) begin
                                state_reg <= SFPS_ST_DONE;
                            end else if (cmd_reg == SFPS_CMD_PROG) begin
                                state_reg <= SFPS_ST_LOAD;
                            end else if (cmd_reg == SFPS_CMD_ID_READ) begin
                                state_reg <= SFPS_ST_READ;
                            end else begin
                                state_reg <= SFPS_ST_POLL;
                            end
                        end
                    end
                end
                SFPS_ST_LOAD: begin
                    if (late_reg) begin
                        err_reg <= 1'b1;
                    end
                    if (wr_end) begin
                        idx_reg <= idx_reg + 8'h01;
                        if (idx_reg == `SFPS_BYTE_LAST) begin
                            state_reg <= SFPS_ST_POLL;
                        end
                    end
                end
                SFPS_ST_POLL: begin
                    if (wc_reg >= `SFPS_TMR_W'(WC_CYC)) begin
                        err_reg <= 1'b1;
                        state_reg <= SFPS_ST_DONE;
                    end else if (rd_sample && have_prev_reg &&
                                 (dq_s2_reg[`SFPS_TOG_BIT] == prev_tog_reg)) begin
                        state_reg <= SFPS_ST_DONE;
                    end
                end
                SFPS_ST_READ: begin
                    if (rd_end) begin
                        if (cmd_reg == SFPS_CMD_ID_READ) begin
                            exit_reg <= 1'b1;
                            state_reg <= SFPS_ST_CMD;
                        end else begin
                            state_reg <= SFPS_ST_DONE;
                        end
                    end
                end
                SFPS_ST_DONE: begin
                    state_reg <= SFPS_ST_IDLE;
                end
                default: begin
                    state_reg <= SFPS_ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Toggle polling and program cycle timeout

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || state_reg != SFPS_ST_POLL) begin
            have_prev_reg <= 1'b0;
            prev_tog_reg <= 1'b0;
            wc_reg <= '0;
        end else begin
            wc_reg <= wc_reg + `SFPS_TMR_W'(1);
            if (rd_sample) begin
                have_prev_reg <= 1'b1;
                prev_tog_reg <= dq_s2_reg[`SFPS_TOG_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Byte load window watchdog

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || state_reg != SFPS_ST_LOAD) begin
            gap_reg <= '0;
            late_reg <= 1'b0;
        end else if (cnt_reg == `SFPS_WR_LO_FIRST) begin
            gap_reg <= '0;
        end else begin
            gap_reg <= gap_reg + `SFPS_TMR_W'(1);
            if (gap_reg >= `SFPS_TMR_W'(BLC_CYC)) begin
                late_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ce_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            we_n_o <= 1'b1;
            byte_address_lines_o <= 18'h00000;
            data_byte_lines_o <= 8'h00;
            data_byte_lines_oe_o <= 1'b0;
        end else begin
            ce_n_o <= !(is_wr || is_rd);
            oe_n_o <= !(is_rd && cnt_reg < `SFPS_RD_SAMPLE);
            we_n_o <= !(is_wr && cnt_reg >= `SFPS_WR_LO_FIRST &&
                        cnt_reg < `SFPS_WR_LO_END);
            data_byte_lines_oe_o <= is_wr;
            if (state_reg == SFPS_ST_CMD) begin
                byte_address_lines_o <= {3'b000, seq_now[22:8]};
                data_byte_lines_o <= seq_now[7:0];
            end else if (state_reg == SFPS_ST_LOAD) begin
                byte_address_lines_o <= {addr_reg[`SFPS_SECT_HI:`SFPS_SECT_LO],
                                         idx_reg};
                if (cnt_reg == `SFPS_BUF_FETCH) begin
                    data_byte_lines_o <= buf_rdata;
                end
            end else if (is_rd) begin
                byte_address_lines_o <= addr_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Response

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 8'h00;
            rsp_err_o <= 1'b0;
            busy_o <= 1'b0;
            req_ready_o <= 1'b0;
        end else begin
            rsp_valid_o <= (state_reg == SFPS_ST_DONE);
            rsp_err_o <= (state_reg == SFPS_ST_DONE) && err_reg;
            if (state_reg == SFPS_ST_READ && rd_sample) begin
                rsp_data_o <= dq_s2_reg;
            end
            busy_o <= !(state_reg == SFPS_ST_IDLE && !req_valid_i) &&
                      !(state_reg == SFPS_ST_DONE);
            req_ready_o <= (state_reg == SFPS_ST_DONE) ||
                           (state_reg == SFPS_ST_IDLE && !req_valid_i);
        end
    end

endmodule : sfps_host

`default_nettype wire

/* File: tb/sfps_host_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module sfps_host_monitor (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Request and response
    input wire logic req_valid_i,
    input wire logic [2:0] req_cmd_i,
    input wire logic req_ready_o,
    input wire logic rsp_valid_o,
    input wire logic rsp_err_o,
    input wire logic busy_o,
    // Flash pins
    input wire logic ce_n_o,
    input wire logic oe_n_o,
    input wire logic we_n_o,
    input wire logic [17:0] byte_address_lines_o,
    input wire logic [7:0] data_byte_lines_o,
    input wire logic data_byte_lines_oe_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_bad_take;
        req_valid_i && req_ready_o && (req_cmd_i > 3'h4);
    endsequence
    sequence s_err_rsp;
        ##[1:3] rsp_valid_o && rsp_err_o;
    endsequence
    chk_illegal_cmd: assert property (s_bad_take |-> ce_n_o throughout s_err_rsp)
        else $error("illegal command not refused");
    chk_take_ready: assert property (req_valid_i && req_ready_o |=> !req_ready_o)
        else $error("ready stayed high after take");
    chk_rsp_pulse: assert property (rsp_valid_o |=> !rsp_valid_o)
        else $error("response longer than one cycle");
    chk_err_valid: assert property (rsp_err_o |-> rsp_valid_o)
        else $error("error without response");
    chk_write_excl: assert property (!we_n_o |-> oe_n_o && !ce_n_o && data_byte_lines_oe_o)
        else $error("write strobe with output enable");
    chk_no_contend: assert property (!oe_n_o |-> !data_byte_lines_oe_o)
        else $error("host drives data while reading");
    chk_wr_pulse: assert property ($fell(we_n_o) |-> (!we_n_o) [*8] ##1 we_n_o)
        else $error("write pulse width wrong");
    chk_wr_recover: assert property ($rose(we_n_o) |-> we_n_o [*8])
        else $error("write high time too short");
    chk_wr_stable: assert property (!we_n_o || $rose(we_n_o) |->
        $stable(byte_address_lines_o) &&
        ($fell(we_n_o) || $stable(data_byte_lines_o)))
        else $error("address or data moved in write");
    chk_oe_gap: assert property ($rose(oe_n_o) |-> oe_n_o [*6])
        else $error("output enable high pulse too short");
    chk_reset_idle: assert property ($fell(sys_rst_i) |->
        ce_n_o && oe_n_o && we_n_o && !busy_o && !data_byte_lines_oe_o)
        else $error("pins not idle after reset");
endmodule : sfps_host_monitor
bind sfps_host sfps_host_monitor u_sfps_host_monitor (.*);
`default_nettype wire

/* File: tb/sfps_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sfps_flash_model #(
    parameter logic [7:0] MAKER_ID = 8'h3C, // arbitrary
    parameter logic [7:0] PART_ID = 8'h5A, // arbitrary
    parameter logic [14:0] AA = 15'h0001,
    parameter logic [14:0] AB = 15'h0002,
    parameter logic [7:0] DA = 8'h01,
    parameter logic [7:0] DB = 8'h02,
    parameter real BLC_NS = 1000.0
) (
    // Strobes and address
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic [17:0] addr_i,
    // Data byte
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o
);
    logic [7:0] mem [logic [17:0]];
    logic [7:0] buff [256];
    logic [255:0] ldm;
    logic [22:0] h0 = '0, h1 = '0;
    logic [17:0] wa, pa;
    logic [9:0] sect;
    logic [7:0] rv = 8'h00;
    logic busy = 1'b0, tog = 1'b0, last7 = 1'b0, lk_lo = 1'b0, lk_hi = 1'b0;
    logic idm = 1'b0;
    wire logic erase_ok = !(lk_lo || lk_hi);
    logic loading = 1'b0, lock_arm = 1'b0, pend = 1'b0, pv = 1'b0;
    int nload, prog_ns = 4000, proto_err = 0;
    realtime t_last;
    always @(negedge we_n_i) wa = addr_i;
    always @(posedge we_n_i) begin
        if (!ce_n_i && !busy) begin
            if (loading) begin
                if (nload == 0) sect = wa[17:8];
                if (wa[17:8] != sect || $realtime - t_last > BLC_NS) proto_err++;
                buff[wa[7:0]] = dq_i;
                ldm[wa[7:0]] = 1'b1;
                last7 = dq_i[7];
                t_last = $realtime;
                nload++;
                if (nload == 256) begin
                    loading = 1'b0;
                    pend = 1'b1;
                    busy = 1'b1;
                end
            end else if (lock_arm) begin
                lock_arm = 1'b0;
                if (dq_i == 8'h00) lk_lo = 1'b1;
                else lk_hi = 1'b1;
                busy = 1'b1;
            end else begin
                if (h1 == {AA, DA} && h0 == {AB, DB} && wa[14:0] == AA) begin
                    loading = (dq_i == 8'h03);
                    lock_arm = (dq_i == 8'h06);
                    if (dq_i == 8'h04) idm = 1'b1;
                    if (dq_i == 8'h05) idm = 1'b0;
                    nload = 0;
                    ldm = '0;
                    t_last = $realtime;
                end
                h1 = h0;
                h0 = {wa[14:0], dq_i};
            end
        end
    end
    always @(posedge busy) begin
        pv = 1'b0;
        #(prog_ns);
        if (pend) for (int i = 0; i < 256; i++) mem[{sect, 8'(i)}] = ldm[i] ? buff[i] : 8'hXX;
        pend = 1'b0;
        busy = 1'b0;
    end
    always @(negedge oe_n_i or negedge ce_n_i) begin
        if (busy && !ce_n_i && !oe_n_i) begin
            tog = ~tog;
            if (pv && addr_i != pa) proto_err++;
            pa = addr_i;
            pv = 1'b1;
        end
    end
    always @* begin
        if (!ce_n_i && !oe_n_i && we_n_i) begin
            if (busy) rv = {~last7, tog, 6'h00};
            else if (idm && addr_i == 18'h00002) rv = {7'h7F, lk_lo};
            else if (idm && addr_i == 18'h3FFF2) rv = {7'h7F, lk_hi};
            else if (idm) rv = addr_i[0] ? PART_ID : MAKER_ID;
            else rv = mem.exists(addr_i) ? mem[addr_i] : 8'hFF;
            dq_o = rv;
        end else begin
            dq_o = ~rv;
        end
    end
endmodule : sfps_flash_model
`default_nettype wire

/* File: tb/sfps_host_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sfps_host_tb;
    import sfps_pkg::*;
    localparam logic [7:0] MAKER_ID = 8'h3C; // arbitrary
    localparam logic [7:0] PART_ID = 8'h5A; // arbitrary
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic [2:0] req_cmd_i = 3'h0;
    logic [17:0] req_addr_i = 18'h00000;
    logic buf_wr_i = 1'b0;
    logic [7:0] buf_waddr_i = 8'h00;
    logic [7:0] buf_wdata_i = 8'h00;
    logic req_ready_o, rsp_valid_o, rsp_err_o, busy_o, ce_n_o, oe_n_o, we_n_o;
    logic [7:0] rsp_data_o, data_byte_lines_o, dev_q;
    logic data_byte_lines_oe_o;
    logic [17:0] byte_address_lines_o;
    wire logic [7:0] data_byte_lines_i = data_byte_lines_oe_o ? data_byte_lines_o : dev_q;
    int failures = 0;
    int compares = 0;
    logic [31:0] seed = 32'h00000043;
    logic [9:0] expq [$];
    logic [9:0] ex;
    logic [7:0] img [256];
    always #12.5 core_clk_i = ~core_clk_i;
    sfps_host #(.BLC_CYC(40), .WC_CYC(2000)) u_sfps_host (.*);
    sfps_flash_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) u_sfps_flash_model (
        .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o), .addr_i(byte_address_lines_o),
        .dq_i(data_byte_lines_i), .dq_o(dev_q));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic finish_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    // Request, expectation {check data, error, data}
    task automatic req(input logic [2:0] cmd, input logic [17:0] a, input logic [9:0] exp);
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 20000) begin
            @(posedge core_clk_i);
            #2;
            n++;
        end
        req_valid_i = 1'b1;
        req_cmd_i = cmd;
        req_addr_i = a;
        expq.push_back(exp);
        @(posedge core_clk_i);
        #2;
        req_valid_i = 1'b0;
        do begin
            @(posedge core_clk_i);
            #2;
            n++;
        end while (rsp_valid_o !== 1'b1 && n < 20000);
        if (n >= 20000) failures++;
    endtask : req
    task automatic prog(input logic [9:0] sect, input int pns, input logic err);
        u_sfps_flash_model.prog_ns = pns;
        for (int i = 0; i < 256; i++) begin
            seed = xs(seed);
            img[i] = seed[7:0];
            @(posedge core_clk_i);
            #2;
            buf_wr_i = 1'b1;
            buf_waddr_i = 8'(i);
            buf_wdata_i = seed[7:0];
        end
        @(posedge core_clk_i);
        #2;
        buf_wr_i = 1'b0;
        req(3'h1, {sect, 8'h00}, {1'b0, err, 8'h00});
        if (!err) for (int i = 0; i < 256; i += 51) req(3'h0, {sect, 8'(i)}, {2'b10, img[i]});
        $display("test program done");
    endtask : prog
    task automatic idtest(input logic [7:0] lk);
        req(3'h2, 18'h00000, {2'b10, MAKER_ID});
        req(3'h2, 18'h00001, {2'b10, PART_ID});
        req(3'h2, 18'h00002, {2'b10, lk});
        req(3'h2, 18'h3FFF2, {2'b10, lk});
        req(3'h0, 18'h3FFFF, {2'b10, img[255]});
        $display("test id_read done");
    endtask : idtest
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk_i) begin
        if (rsp_valid_o === 1'b1) begin
            if (expq.size() == 0) begin
                failures++;
                $display("FAIL rsp expected none seen one");
            end else begin
                ex = expq.pop_front();
                check("rsp_err", {7'h00, rsp_err_o}, {7'h00, ex[8]});
                if (ex[9]) check("rsp_data", rsp_data_o, ex[7:0]);
            end
        end
    end
    initial begin
        #2000000;
        failures++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge core_clk_i);
        #2;
        sys_rst_i = 1'b0;
        for (int c = 5; c < 8; c++) req(3'(c), 18'h00000, 10'h100);
        $display("test illegal_cmd done");
        prog(10'h005, 4000, 1'b0);
        prog(10'h3FF, 40000, 1'b0);
        idtest(8'hFE);
        check("erase_ok", {7'h00, u_sfps_flash_model.erase_ok}, 8'h01);
        req(3'h3, 18'h00000, 10'h000);
        req(3'h4, 18'h00000, 10'h000);
        idtest(8'hFF);
        check("erase_ok", {7'h00, u_sfps_flash_model.erase_ok}, 8'h00);
        $display("test lockout done");
        prog(10'h100, 80000, 1'b1);
        check("proto", 8'(u_sfps_flash_model.proto_err), 8'h00);
        finish_test();
    end
endmodule : sfps_host_tb
`default_nettype wire
